// ==== common/dtm_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the DDR timing and mode configuration slice
// Assumes: Controller clock is the DRAM clock, 25 MHz
// Notes:   Offsets are byte addresses on the plain register port
//////////////////////////////////////////////////////////////////////////////
package dtm_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_CMD_TIMING = 8'h60;
    localparam logic [7:0] OFS_CTRL_MODE = 8'h68;

    // dram_command_timing fields
    localparam int TM_RAS_MAX_BIT = 10;
    localparam int TM_RAS_MIN_LSB = 7;
    localparam int TM_CAS_LSB = 5;
    localparam int TM_RCD_LSB = 2;
    localparam int TM_RP_LSB = 0;
    localparam logic [31:0] TM_WR_MASK = 32'h0000_07ef;
    localparam logic [31:0] TM_RESET = 32'h0000_0000;

    // dram_controller_mode fields
    localparam int MD_INIT_BIT = 29;
    localparam int MD_CHANNEL_ORGANISATION_LSB = 21;
    localparam int MD_RATE_LSB = 8;
    localparam int MD_SMS_LSB = 4;
    localparam int MD_TYPE_LSB = 0;
    localparam logic [31:0] MD_WR_MASK = 32'h2060_0770;
    localparam logic [31:0] MD_RESET = 32'h0000_0001;
    localparam logic [1:0] MEM_TYPE_DDR = 2'h1;

    // Timing figures and their cycle counts
    localparam int RAS_MIN_BASE_CLKS = 10;
    localparam int RAS_MAX_LONG_NS = 120000;
    localparam int RAS_MAX_SHORT_NS = 70000;
    localparam int RAS_MAX_LONG_CLKS = RAS_MAX_LONG_NS / CLK_PERIOD_NS;
    localparam int RAS_MAX_SHORT_CLKS = RAS_MAX_SHORT_NS / CLK_PERIOD_NS;
    localparam int ROW_CLOSE_MARGIN_CLKS = 16;
    localparam int REF_15U6_NS = 15600;
    localparam int REF_7U8_NS = 7800;
    localparam int REF_64U_NS = 64000;
    localparam int REF_15U6_CLKS = REF_15U6_NS / CLK_PERIOD_NS;
    localparam int REF_7U8_CLKS = REF_7U8_NS / CLK_PERIOD_NS;
    localparam int REF_64U_CLKS = REF_64U_NS / CLK_PERIOD_NS;
    localparam int REF_FAST_CLKS = 64;

    typedef enum logic [1:0] {
        DTM_CHANNEL_ORGANISATION_SINGLE = 2'h0,
        DTM_CHANNEL_ORGANISATION_DUAL_LINEAR = 2'h1,
        DTM_CHANNEL_ORGANISATION_DUAL_TILED = 2'h2,
        DTM_CHANNEL_ORGANISATION_RSVD = 2'h3
    } dtm_channel_organisation_org_t;

    typedef enum logic [2:0] {
        DTM_SMS_POST_RESET = 3'h0,
        DTM_SMS_NOP = 3'h1,
        DTM_SMS_PRECHARGE_ALL = 3'h2,
        DTM_SMS_MODE_SET = 3'h3,
        DTM_SMS_EXT_MODE_SET = 3'h4,
        DTM_SMS_RSVD = 3'h5,
        DTM_SMS_REFRESH = 3'h6,
        DTM_SMS_NORMAL = 3'h7
    } dtm_sms_t;

    localparam logic [2:0] REF_CODE_15U6 = 3'h1;
    localparam logic [2:0] REF_CODE_7U8 = 3'h2;
    localparam logic [2:0] REF_CODE_64U = 3'h3;
    localparam logic [2:0] REF_CODE_FAST = 3'h7;

    // Refresh period in clocks, zero when refresh is off or code reserved
    function automatic logic [11:0] dtm_refresh_clks(input logic [2:0] code);
        logic [11:0] clks;
        clks = 12'h0;
        unique case (code)
            REF_CODE_15U6: clks = 12'(REF_15U6_CLKS);
            REF_CODE_7U8: clks = 12'(REF_7U8_CLKS);
            REF_CODE_64U: clks = 12'(REF_64U_CLKS);
            REF_CODE_FAST: clks = 12'(REF_FAST_CLKS);
            default: clks = 12'h0;
        endcase
        return clks;
    endfunction

endpackage

// ==== rtl/dtm_gap_timer.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Loadable down counter marking a minimum or maximum spacing
// Assumes: Load value is the wanted clocks minus one
// Notes:   done_out is high whenever the count has run out
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module dtm_gap_timer
    import dtm_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic [W-1:0] load_val_in,
    output logic done_out
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } dtm_gap_state_t;

    dtm_gap_state_t s;
    dtm_gap_state_t next_s;

    always_comb begin
        next_s = s;
        if (load_in) begin
            next_s.cnt = load_val_in;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done_out = (s.cnt == '0);

endmodule

// ==== rtl/dtm_refresh_timer.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Periodic refresh request generator
// Assumes: Rate code comes from the mode register on the same clock
// Notes:   A change of rate restarts the period
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module dtm_refresh_timer
    import dtm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [2:0] rate_code_in,
    output logic refresh_out
);

    typedef struct packed {
        logic [2:0] code;
        logic [11:0] cnt;
        logic pulse;
    } dtm_ref_state_t;

    dtm_ref_state_t s;
    dtm_ref_state_t next_s;
    logic [11:0] period;

    always_comb begin
        next_s = s;
        period = dtm_refresh_clks(rate_code_in);
        next_s.code = rate_code_in;
        next_s.pulse = 1'b0;
        if (period == 12'h0 || rate_code_in != s.code) begin
            next_s.cnt = 12'h0;
        end else if (s.cnt == period - 12'h1) begin
            next_s.cnt = 12'h0;
            next_s.pulse = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 12'h1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign refresh_out = s.pulse;

endmodule

// ==== rtl/dtm_ctrl.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: DDR command timing and controller mode registers with spacing guards
// Assumes: clk_sys_in is the DRAM clock; scheduler inputs share that clock
// Notes:   Reserved timing codes decode to the slowest legal setting; reserved refresh codes turn refresh off
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module dtm_ctrl
    import dtm_pkg::*;
#(
    parameter int CKE_W = 4
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic sched_activate_in,
    input wire logic sched_precharge_in,
    input wire logic sched_rw_in,
    output logic act_allow_out,
    output logic pre_allow_out,
    output logic rw_allow_out,
    output logic row_close_req_out,
    output logic refresh_req_out,
    output logic [3:0] cas_half_clks_out,
    output logic [1:0] channel_org_out,
    output logic lockstep_out,
    output logic init_done_out,
    output logic [CKE_W-1:0] cke_out,
    output logic [2:0] special_cmd_out
);

    typedef struct packed {
        logic [31:0] timing;
        logic [31:0] mode;
        logic [31:0] rdata;
        logic cke;
        logic row_open;
        logic [3:0] ras_min;
        logic [3:0] cas_half;
        logic [2:0] rcd;
        logic [2:0] rp;
        logic [11:0] row_max;
        logic lockstep;
    } dtm_ctrl_state_t;

    dtm_ctrl_state_t s;
    dtm_ctrl_state_t next_s;

    logic wr_timing;
    logic wr_mode;
    logic ras_min_done;
    logic rcd_done;
    logic rp_done;
    logic row_max_done;

    //////////////////////////////////////////////////////////////////////////
    // Field decodes; reserved codes fall back to the slowest legal setting

    function automatic logic [3:0] ras_min_clks(input logic [2:0] code);
        logic [3:0] clks;
        clks = 4'(RAS_MIN_BASE_CLKS);
        if (code <= 3'h5) begin
            clks = 4'(RAS_MIN_BASE_CLKS) - {1'b0, code};
        end
        return clks;
    endfunction

    function automatic logic [3:0] cas_half_clks(input logic [1:0] code);
        logic [3:0] half;
        unique case (code)
            2'h0: half = 4'h5;
            2'h1: half = 4'h4;
            default: half = 4'h6;
        endcase
        return half;
    endfunction

    function automatic logic [2:0] short_gap_clks(input logic [1:0] code);
        logic [2:0] clks;
        clks = 3'h4;
        if (code != 2'h3) begin
            clks = 3'h4 - {1'b0, code};
        end
        return clks;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Register port and configuration state

    assign wr_timing = reg_wr_in && (reg_addr_in == OFS_CMD_TIMING);
    assign wr_mode = reg_wr_in && (reg_addr_in == OFS_CTRL_MODE);

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;
        if (wr_timing) begin
            next_s.timing = reg_wdata_in & TM_WR_MASK;
        end
        if (wr_mode) begin
            next_s.mode = (reg_wdata_in & MD_WR_MASK) | MD_RESET;
            if (reg_wdata_in[MD_SMS_LSB +: 3] != DTM_SMS_POST_RESET) begin
                next_s.cke = 1'b1;
            end
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_CMD_TIMING: next_s.rdata = s.timing;
                OFS_CTRL_MODE: next_s.rdata = s.mode;
                default: next_s.rdata = 32'h0;
            endcase
        end
        // Decoded copies track the register value in the same cycle
        next_s.ras_min = ras_min_clks(next_s.timing[TM_RAS_MIN_LSB +: 3]);
        next_s.cas_half = cas_half_clks(next_s.timing[TM_CAS_LSB +: 2]);
        next_s.rcd = short_gap_clks(next_s.timing[TM_RCD_LSB +: 2]);
        next_s.rp = short_gap_clks(next_s.timing[TM_RP_LSB +: 2]);
        if (next_s.timing[TM_RAS_MAX_BIT]) begin
            next_s.row_max = 12'(RAS_MAX_SHORT_CLKS);
        end else begin
            next_s.row_max = 12'(RAS_MAX_LONG_CLKS);
        end
        // Only the matched dual modes run the channels in lock step
        next_s.lockstep = (next_s.mode[MD_CHANNEL_ORGANISATION_LSB +: 2] == DTM_CHANNEL_ORGANISATION_DUAL_LINEAR) ||
                          (next_s.mode[MD_CHANNEL_ORGANISATION_LSB +: 2] == DTM_CHANNEL_ORGANISATION_DUAL_TILED);
        if (sched_activate_in) begin
            next_s.row_open = 1'b1;
        end else if (sched_precharge_in) begin
            next_s.row_open = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s.timing <= TM_RESET;
            s.mode <= MD_RESET;
            s.rdata <= 32'h0;
            s.cke <= 1'b0;
            s.row_open <= 1'b0;
            s.ras_min <= 4'(RAS_MIN_BASE_CLKS);
            s.cas_half <= 4'h5;
            s.rcd <= 3'h4;
            s.rp <= 3'h4;
            s.row_max <= 12'(RAS_MAX_LONG_CLKS);
            s.lockstep <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command spacing guards. One tracker serves both channels, so a command
    // on either channel holds off the next one on the other as well.

    dtm_gap_timer #(.W(12)) u_ras_min (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .load_in(sched_activate_in),
        .load_val_in({8'h0, s.ras_min} - 12'h1),
        .done_out(ras_min_done)
    );

    dtm_gap_timer #(.W(12)) u_rcd (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .load_in(sched_activate_in),
        .load_val_in({9'h0, s.rcd} - 12'h1),
        .done_out(rcd_done)
    );

    dtm_gap_timer #(.W(12)) u_rp (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .load_in(sched_precharge_in),
        .load_val_in({9'h0, s.rp} - 12'h1),
        .done_out(rp_done)
    );

    // Margin leaves the scheduler time to issue the precharge
    dtm_gap_timer #(.W(12)) u_row_max (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .load_in(sched_activate_in),
        .load_val_in(s.row_max - 12'(ROW_CLOSE_MARGIN_CLKS) - 12'h1),
        .done_out(row_max_done)
    );

    dtm_refresh_timer u_refresh (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .rate_code_in(s.mode[MD_RATE_LSB +: 3]),
        .refresh_out(refresh_req_out)
    );

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign act_allow_out = rp_done && !s.row_open;
    assign pre_allow_out = ras_min_done && s.row_open;
    assign rw_allow_out = rcd_done && s.row_open;
    assign row_close_req_out = row_max_done && s.row_open;
    assign reg_rdata_out = s.rdata;
    assign cas_half_clks_out = s.cas_half;
    assign channel_org_out = s.mode[MD_CHANNEL_ORGANISATION_LSB +: 2];
    assign lockstep_out = s.lockstep;
    assign init_done_out = s.mode[MD_INIT_BIT];
    assign cke_out = {CKE_W{s.cke}};
    // Processor accesses become this command while not in normal mode
    assign special_cmd_out = s.mode[MD_SMS_LSB +: 3];

    //////////////////////////////////////////////////////////////////////////
    // Checks

    logic [11:0] since_act;
    logic [11:0] since_pre;
    logic [11:0] since_ref;
    logic [2:0] prev_rate;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            since_act <= 12'hfff;
            since_pre <= 12'hfff;
            since_ref <= 12'h0;
            prev_rate <= 3'h0;
        end else begin
            prev_rate <= s.mode[MD_RATE_LSB +: 3];
            since_act <= sched_activate_in ? 12'h1 : (since_act == 12'hfff ? since_act : since_act + 12'h1);
            since_pre <= sched_precharge_in ? 12'h1 : (since_pre == 12'hfff ? since_pre : since_pre + 12'h1);
            // Rate change restarts the timer one edge later, so count from zero
            if (prev_rate != s.mode[MD_RATE_LSB +: 3]) begin
                since_ref <= 12'h0;
            end else if (refresh_req_out) begin
                since_ref <= 12'h1;
            end else if (since_ref != 12'hfff) begin
                since_ref <= since_ref + 12'h1;
            end
        end
    end

    sequence s_pre_blocked_two;
        !pre_allow_out ##1 !pre_allow_out;
    endsequence

    property p_cross_channel;
        @(posedge clk_sys_in) disable iff (reset_in)
        sched_activate_in |=> s_pre_blocked_two;
    endproperty
    a_cross_channel: assert property (p_cross_channel) else $error("precharge allowed right after activate");

    property p_ras_min;
        @(posedge clk_sys_in) disable iff (reset_in)
        (pre_allow_out && since_act != 12'hfff) |-> since_act >= {8'h0, s.ras_min};
    endproperty
    a_ras_min: assert property (p_ras_min) else $error("precharge allowed before minimum row time");

    property p_rcd;
        @(posedge clk_sys_in) disable iff (reset_in)
        (sched_activate_in && !sched_precharge_in) ##1 (!sched_activate_in && !sched_precharge_in)[*3]
            |-> (rw_allow_out == (since_act >= {9'h0, s.rcd}));
    endproperty
    a_rcd: assert property (p_rcd) else $error("access spacing after activate wrong");

    property p_rp;
        @(posedge clk_sys_in) disable iff (reset_in)
        (act_allow_out && since_pre != 12'hfff) |-> since_pre >= {9'h0, s.rp};
    endproperty
    a_rp: assert property (p_rp) else $error("activate allowed before precharge time");

    property p_refresh_period;
        @(posedge clk_sys_in) disable iff (reset_in)
        (refresh_req_out && $stable(s.mode[MD_RATE_LSB +: 3]))
            |-> since_ref == dtm_refresh_clks(s.mode[MD_RATE_LSB +: 3]);
    endproperty
    a_refresh_period: assert property (p_refresh_period) else $error("refresh period wrong");

    property p_refresh_fast;
        @(posedge clk_sys_in) disable iff (reset_in)
        (refresh_req_out && s.mode[MD_RATE_LSB +: 3] == REF_CODE_FAST) |=> !refresh_req_out [*8];
    endproperty
    a_refresh_fast: assert property (p_refresh_fast) else $error("fast refresh too frequent");

    property p_cke_gate;
        @(posedge clk_sys_in) disable iff (reset_in)
        (cke_out == '0 && !(wr_mode && reg_wdata_in[MD_SMS_LSB +: 3] != 3'h0)) |=> cke_out == '0;
    endproperty
    a_cke_gate: assert property (p_cke_gate) else $error("clock enable rose without special mode write");

    property p_cke_rise;
        @(posedge clk_sys_in) disable iff (reset_in)
        (wr_mode && reg_wdata_in[MD_SMS_LSB +: 3] != 3'h0) |=> (cke_out == '1) [*2];
    endproperty
    a_cke_rise: assert property (p_cke_rise) else $error("clock enable not raised by mode write");

    property p_special_cmd;
        @(posedge clk_sys_in) disable iff (reset_in)
        wr_mode |=> special_cmd_out == $past(reg_wdata_in[MD_SMS_LSB +: 3]);
    endproperty
    a_special_cmd: assert property (p_special_cmd) else $error("special command not taken from write");

    property p_type_ro;
        @(posedge clk_sys_in) disable iff (reset_in)
        (reg_rd_in && reg_addr_in == OFS_CTRL_MODE) |=> reg_rdata_out[1:0] == MEM_TYPE_DDR;
    endproperty
    a_type_ro: assert property (p_type_ro) else $error("memory type field wrong");

    property p_reserved;
        @(posedge clk_sys_in) disable iff (reset_in)
        (reg_rd_in && reg_addr_in == OFS_CMD_TIMING) |=> (reg_rdata_out & ~TM_WR_MASK) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved timing bits not zero");

    property p_lockstep;
        @(posedge clk_sys_in) disable iff (reset_in)
        lockstep_out |-> (channel_org_out == DTM_CHANNEL_ORGANISATION_DUAL_LINEAR || channel_org_out == DTM_CHANNEL_ORGANISATION_DUAL_TILED);
    endproperty
    a_lockstep: assert property (p_lockstep) else $error("lock step outside dual mode");

    property p_row_close;
        @(posedge clk_sys_in) disable iff (reset_in)
        (s.row_open && since_act != 12'hfff && since_act >= s.row_max - 12'(ROW_CLOSE_MARGIN_CLKS))
            |-> row_close_req_out;
    endproperty
    a_row_close: assert property (p_row_close) else $error("row not closed before maximum time");

endmodule

// ==== verif/dtm_sched_model.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Scheduler stand-in that issues activate and precharge pulses
// Assumes: Commands for either channel share one set of lines
// Notes:   One-cycle pulses, never both at once
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module dtm_sched_model (
    input wire logic clk_sys_in,
    output logic act_out,
    output logic pre_out
);
    initial begin
        act_out = 1'b0;
        pre_out = 1'b0;
    end

    // Either channel lands on the same line, so spacing is shared
    task automatic issue(input logic is_act);
        @(posedge clk_sys_in);
        act_out <= is_act;
        pre_out <= !is_act;
        @(posedge clk_sys_in);
        act_out <= 1'b0;
        pre_out <= 1'b0;
    endtask
endmodule

// ==== verif/tb_ddr_timing_mode_config.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the timing and mode registers
// Assumes: 25 MHz clock, asynchronous active-high reset
// Notes:   Reset values first, then row table, spacing, refresh and a second reset
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module tb_ddr_timing_mode_config
    import dtm_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rd;
        logic [10:0] outs;
    } dtm_row_t;

    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata;
    logic act, pre, act_allow, pre_allow, rw_allow, row_close, refresh, lockstep, init_done;
    logic [3:0] cas_half;
    logic [1:0] channel_organisation;
    logic [3:0] cke;
    logic [2:0] spc;
    int error_cnt = 0;
    int cmp_count = 0;
    // outs: cas half clocks, lockstep, channel, special mode, init flag
    // Dual rows stand for identically populated channels
    dtm_row_t rows [12] = '{'{8'h60, 32'hffffffff, 32'h000007ef, 11'h300},
        '{8'h60, 32'h00000000, 32'h00000000, 11'h280}, '{8'h60, 32'h00000020, 32'h00000020, 11'h200},
        '{8'h60, 32'h00000040, 32'h00000040, 11'h300}, '{8'h68, 32'h00200070, 32'h00200071, 11'h35e},
        '{8'h68, 32'h00400010, 32'h00400011, 11'h362}, '{8'h68, 32'h20600020, 32'h20600021, 11'h335},
        '{8'h68, 32'hffffffff, 32'h20600771, 11'h33f}, '{8'h68, 32'h00000030, 32'h00000031, 11'h306},
        '{8'h68, 32'h00000040, 32'h00000041, 11'h308}, '{8'h68, 32'h00000060, 32'h00000061, 11'h30c},
        '{8'h70, 32'hffffffff, 32'h00000000, 11'h30c}};
    // Timing word, then activate-to-access, ras min, precharge-to-activate, row close
    logic [31:0] tw [7] = '{32'h0, 32'h68a, 32'h085, 32'h10f, 32'h580, 32'h208, 32'h300};
    int sp [7][4] = '{'{4, 10, 4, 2984}, '{2, 5, 2, 1734}, '{3, 9, 3, 2984}, '{4, 8, 4, 2984},
        '{4, 7, 4, 1734}, '{2, 6, 4, 2984}, '{4, 10, 4, 2984}};
    logic [2:0] rcode [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    int rgap [4] = '{390, 195, 1600, 64};

    dtm_ctrl #(.CKE_W(4)) i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .sched_activate_in(act), .sched_precharge_in(pre), .sched_rw_in(1'b0), .act_allow_out(act_allow),
        .pre_allow_out(pre_allow), .rw_allow_out(rw_allow), .row_close_req_out(row_close),
        .refresh_req_out(refresh), .cas_half_clks_out(cas_half), .channel_org_out(channel_organisation),
        .lockstep_out(lockstep), .init_done_out(init_done), .cke_out(cke), .special_cmd_out(spc));
    dtm_sched_model i_sched (.clk_sys_in(clk_sys_in), .act_out(act), .pre_out(pre));

    always #20 clk_sys_in = ~clk_sys_in;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_reset();
        logic [31:0] d;
        chk("cke", 32'(cke), 32'h0);
        chk("special", 32'(spc), 32'h0);
        chk("cas", 32'(cas_half), 32'h5);
        chk("allows", {29'h0, act_allow, pre_allow, rw_allow}, 32'h4);
        reg_read(OFS_CMD_TIMING, d);
        chk("timing reset", d, 32'h0);
        reg_read(OFS_CTRL_MODE, d);
        chk("mode reset", d, 32'h1);
        @(posedge clk_sys_in);
        #1;
        chk("rdata idle", rdata, 32'h0);
    endtask

    // Returns zero when no pulse shows within the bound
    task automatic refresh_gap(input int bound, output int gap);
        gap = 0;
        for (int n = 1; n <= bound; n++) begin
            @(posedge clk_sys_in);
            #1;
            if (refresh === 1'b1) begin
                gap = n;
                break;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #4000000;
        error_cnt++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        int rw_n, pre_n, close_n, act_n, g;
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        chk_reset();
        reg_write(OFS_CTRL_MODE, 32'h0);
        #1;
        chk("cke after zero mode", 32'(cke), 32'h0);
        for (int i = 0; i < 12; i++) begin
            reg_write(rows[i].addr, rows[i].wdata);
            reg_read(rows[i].addr, d);
            chk("readback", d, rows[i].rd);
            chk("decoded", {21'h0, cas_half, lockstep, channel_organisation, spc, init_done}, {21'h0, rows[i].outs});
        end
        chk("cke on", 32'(cke), 32'hf);
        for (int i = 0; i < 7; i++) begin
            reg_write(OFS_CMD_TIMING, tw[i]);
            i_sched.issue(1'b1);
            rw_n = 0;
            pre_n = 0;
            close_n = 0;
            // Level seen after edge n-1 is the one the scheduler acts on at edge n
            for (int n = 1; n <= 3100 && close_n == 0; n++) begin
                #1;
                if (rw_allow === 1'b1 && rw_n == 0) rw_n = n;
                if (pre_allow === 1'b1 && pre_n == 0) pre_n = n;
                if (row_close === 1'b1) close_n = n;
                @(posedge clk_sys_in);
            end
            if (close_n == 0) begin
                error_cnt++;
                complete_run();
            end
            chk("activate to access", rw_n, sp[i][0]);
            chk("ras min", pre_n, sp[i][1]);
            chk("row close", close_n, sp[i][3]);
            i_sched.issue(1'b0);
            act_n = 0;
            for (int n = 1; n <= 10 && act_n == 0; n++) begin
                #1;
                if (act_allow === 1'b1) act_n = n;
                @(posedge clk_sys_in);
            end
            chk("precharge to activate", act_n, sp[i][2]);
        end
        for (int i = 0; i < 4; i++) begin
            reg_write(OFS_CTRL_MODE, 32'h70 | (32'(rcode[i]) << 8));
            refresh_gap(1700, g);
            if (g == 0) begin
                error_cnt++;
                complete_run();
            end
            refresh_gap(1700, g);
            chk("refresh period", g, rgap[i]);
        end
        reg_write(OFS_CTRL_MODE, 32'h70);
        refresh_gap(3, g);
        refresh_gap(500, g);
        chk("refresh off", g, 0);
        @(posedge clk_sys_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        #1;
        chk_reset();
        complete_run();
    end
endmodule
